// ==== ddrc_pkg.sv ====
// Package for the DDR3 device-side command sequencer: commands, modes, timing.
// Assumes one clock standing in for CK, one command per rising edge.
package ddrc_pkg;
  // ---------------------------------------------------------------
  // Command codes {ras_n, cas_n, we_n}
  // ---------------------------------------------------------------
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_NOP = 3'h7;
  // ---------------------------------------------------------------
  // Mode register fields
  // ---------------------------------------------------------------
  localparam logic [1:0] BURST_FIX8 = 2'h0;
  localparam logic [1:0] BURST_OTF = 2'h1;
  localparam logic [1:0] BURST_FIXBC4 = 2'h2;
  localparam int BURST_LSB = 0;
  localparam int CL_LSB = 4;
  localparam int AL_LSB = 8;
  localparam int CWL_LSB = 12;
  localparam int OTF_BIT = 12;
  localparam logic [1:0] AL_ZERO = 2'h0;
  localparam logic [1:0] AL_CL1 = 2'h1;
  localparam logic [1:0] AL_CL2 = 2'h2;
  localparam logic [3:0] CL_RESET = 4'h5;
  localparam logic [3:0] CWL_RESET = 4'h5;
  localparam logic [1:0] BURST_RESET = 2'h0;
  localparam logic [1:0] AL_RESET = 2'h0;
  localparam logic [4:0] BEATS_BL8 = 5'h08;
  localparam logic [4:0] BEATS_BC4 = 5'h04;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int TRFC_NS = 260;
  localparam int TRFC_CYC = (TRFC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TREFI_NS = 7800;
  localparam int TREFI_CYC = TREFI_NS / CLK_PERIOD_NS;
  localparam int REF_POSTPONE_MAX = 9;
  localparam int ODTH4_CYC = 4;
  typedef enum logic [1:0] {
    DDRC_ST_RUN = 2'b01,
    DDRC_ST_PPD = 2'b10
  } ddrc_state_t;
endpackage

// ==== ddrc_beat_buf.sv ====
// Two-entry valid/ready buffer in the read data path.
// Assumes source and sink share clk.
`timescale 1ns/1ps
`default_nettype none
module ddrc_beat_buf #(
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem_q [2];
  logic wr_ptr_q;
  logic rd_ptr_q;
  logic [1:0] count_q;
  logic push;
  logic pop;
  // A full buffer still takes a word in the cycle it hands one out.
  assign in_ready = (count_q != 2'h2) || out_ready;
  assign out_valid = (count_q != 2'h0);
  assign out_data = mem_q[rd_ptr_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end
  full_no_push_a: assert property (@(posedge clk) disable iff (!reset_n)
    count_q == 2'h2 && !pop |=> count_q == 2'h2)
    else $error("buffer lost a word while full");
endmodule
`default_nettype wire

// ==== ddrc_cmd_seq.sv ====
// Device-side DDR3 command sequencer: burst length choice, read and write
// latency, refresh spacing checks, dynamic ODT hold and power-down ODT timing.
// Assumes the controller drives cmd and addr synchronous to clk (CK).
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - An eight-beat burst is used for fixed-8 mode, or on-the-fly mode with A12 high.
// - A four-beat chop is used for fixed-chop mode, or on-the-fly mode with A12 low.
// - Read latency is additive latency plus CAS latency, with AL up to CL minus one.
// - In frozen-DLL precharge power-down the ODT transition window is write latency minus one.
// - Write latency is additive plus CAS write latency; write data starts that late.
module ddrc_cmd_seq
  import ddrc_pkg::*;
#(
  parameter int DQ_W = 16,
  parameter int BANKS = 8,
  parameter int REFI_CYC = TREFI_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [2:0] cmd,
  input wire logic [2:0] bank,
  input wire logic [15:0] addr,
  input wire logic odt,
  input wire logic cke,
  input wire logic [DQ_W-1:0] wr_dq,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [DQ_W-1:0] rd_dq,
  output logic rd_strobe,
  output logic wr_take,
  output logic [DQ_W-1:0] wr_data,
  output logic odt_async,
  output logic [4:0] odt_anpd,
  output logic seq_error
);
  // ---------------------------------------------------------------
  // Mode and latency
  // ---------------------------------------------------------------
  logic [1:0] burst_q;
  logic [3:0] cl_q;
  logic [3:0] cwl_q;
  logic [1:0] al_sel_q;
  logic [4:0] al;
  logic [4:0] rl;
  logic [4:0] wl;
  function automatic logic [4:0] beats_of(input logic [1:0] mode, input logic a12);
    if (mode == BURST_FIX8 || (mode == BURST_OTF && a12)) begin
      return BEATS_BL8;
    end
    return BEATS_BC4;
  endfunction
  always_comb begin
    unique case (al_sel_q)
      AL_CL1: al = {1'b0, cl_q} - 5'h01;
      AL_CL2: al = {1'b0, cl_q} - 5'h02;
      default: al = 5'h00;
    endcase
  end
  assign rl = al + {1'b0, cl_q};
  assign wl = al + {1'b0, cwl_q};
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      burst_q <= BURST_RESET;
      cl_q <= CL_RESET;
      cwl_q <= CWL_RESET;
      al_sel_q <= AL_RESET;
    end else if (cmd == CMD_MRS) begin
      burst_q <= addr[BURST_LSB +: 2];
      cl_q <= addr[CL_LSB +: 4];
      al_sel_q <= addr[AL_LSB +: 2];
      cwl_q <= addr[CWL_LSB +: 4];
    end
  end
  // ---------------------------------------------------------------
  // Bank state and refresh timing
  // ---------------------------------------------------------------
  logic [BANKS-1:0] open_q;
  logic [8:0] rfc_q;
  logic [15:0] refi_q;
  logic err_q;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      open_q <= '0;
    end else if (cmd == CMD_ACT) begin
      open_q[bank] <= 1'b1;
    end else if (cmd == CMD_PRE) begin
      if (addr[10]) begin
        open_q <= '0;
      end else begin
        open_q[bank] <= 1'b0;
      end
    end
  end
  // Refresh and termination misuse is only flagged, never repaired; there is no other recourse.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rfc_q <= '0;
      refi_q <= '0;
      err_q <= 1'b0;
    end else begin
      if (cmd == CMD_REF) begin
        rfc_q <= 9'(TRFC_CYC);
        refi_q <= '0;
        if (open_q != '0 || rfc_q != '0) begin
          err_q <= 1'b1;
        end
        if (32'(refi_q) >= REF_POSTPONE_MAX * REFI_CYC) begin
          err_q <= 1'b1;
        end
      end else begin
        if (rfc_q != '0) begin
          rfc_q <= rfc_q - 9'h001;
          if (cmd != CMD_NOP) begin
            err_q <= 1'b1;
          end
        end
        if (32'(refi_q) >= REF_POSTPONE_MAX * REFI_CYC) begin
          err_q <= 1'b1;
        end else begin
          refi_q <= refi_q + 16'h0001;
        end
      end
    end
  end
  assign seq_error = err_q | odt_early_low_q;
  // ---------------------------------------------------------------
  // Read and write pipelines
  // ---------------------------------------------------------------
  logic [31:0] rd_pipe_q;
  logic [31:0] wr_pipe_q;
  logic [4:0] rd_beats_q;
  logic [4:0] wr_beats_q;
  logic [4:0] rd_left_q;
  logic [4:0] wr_left_q;
  logic [DQ_W-1:0] beat_q;
  logic [DQ_W-1:0] wdata_q;
  logic rd_start;
  logic wr_start;
  logic buf_ready;
  assign rd_start = rd_pipe_q[0];
  assign wr_start = wr_pipe_q[0];
  // Pipes shift toward bit 0; a command loads the bit one below its latency.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rd_pipe_q <= '0;
      wr_pipe_q <= '0;
      rd_beats_q <= BEATS_BL8;
      wr_beats_q <= BEATS_BL8;
    end else begin
      rd_pipe_q <= {1'b0, rd_pipe_q[31:1]};
      wr_pipe_q <= {1'b0, wr_pipe_q[31:1]};
      if (cmd == CMD_RD) begin
        rd_pipe_q[rl - 5'h01] <= 1'b1;
        rd_beats_q <= beats_of(burst_q, addr[OTF_BIT]);
      end
      if (cmd == CMD_WR) begin
        wr_pipe_q[wl - 5'h01] <= 1'b1;
        wr_beats_q <= beats_of(burst_q, addr[OTF_BIT]);
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rd_left_q <= '0;
      wr_left_q <= '0;
      beat_q <= '0;
      wdata_q <= '0;
    end else begin
      if (rd_start) begin
        rd_left_q <= rd_beats_q - 5'h01;
        beat_q <= beat_q + 1'b1;
      end else if (rd_left_q != '0) begin
        rd_left_q <= rd_left_q - 5'h01;
        beat_q <= beat_q + 1'b1;
      end
      if (wr_start) begin
        wr_left_q <= wr_beats_q - 5'h01;
      end else if (wr_left_q != '0) begin
        wr_left_q <= wr_left_q - 5'h01;
      end
      wdata_q <= wr_dq;
    end
  end
  assign rd_strobe = rd_start || (rd_left_q != '0);
  assign wr_take = wr_start || (wr_left_q != '0);
  assign wr_data = wdata_q;
  // The array cannot pause mid-burst, so the buffer absorbs a short receiver stall.
  ddrc_beat_buf #(
    .WIDTH(DQ_W)
  ) u_buf (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(rd_strobe),
    .in_ready(buf_ready),
    .in_data(beat_q),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_dq)
  );
  // ---------------------------------------------------------------
  // ODT behaviour
  // ---------------------------------------------------------------
  ddrc_state_t state_q;
  logic [2:0] odth_q;
  logic odt_early_low_q;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= DDRC_ST_RUN;
    end else begin
      unique case (state_q)
        DDRC_ST_RUN: if (!cke && open_q == '0) state_q <= DDRC_ST_PPD;
        DDRC_ST_PPD: if (cke) state_q <= DDRC_ST_RUN;
        default: state_q <= DDRC_ST_RUN;
      endcase
    end
  end
  assign odt_async = (state_q == DDRC_ST_PPD);
  assign odt_anpd = wl - 5'h01;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      odth_q <= '0;
      odt_early_low_q <= 1'b0;
    end else begin
      if (cmd == CMD_WR && odt && beats_of(burst_q, addr[OTF_BIT]) == BEATS_BC4) begin
        odth_q <= 3'(ODTH4_CYC - 1);
      end else if (odth_q != '0) begin
        odth_q <= odth_q - 3'h1;
        if (!odt) begin
          odt_early_low_q <= 1'b1;
        end
      end
    end
  end
  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  rd_latency_a: assert property (@(posedge clk) disable iff (!reset_n)
    cmd == CMD_RD && rl == 5'h05 |-> ##5 rd_strobe)
    else $error("read data not on time");
  wr_latency_a: assert property (@(posedge clk) disable iff (!reset_n)
    cmd == CMD_WR && wl == 5'h05 |-> ##5 wr_take)
    else $error("write data not taken on time");
  bl8_len_a: assert property (@(posedge clk) disable iff (!reset_n)
    cmd == CMD_RD && rl == 5'h05 && beats_of(burst_q, addr[OTF_BIT]) == BEATS_BL8
    |-> ##5 rd_strobe [*8])
    else $error("eight-beat burst cut short");
  bc4_len_a: assert property (@(posedge clk) disable iff (!reset_n)
    cmd == CMD_RD && rl == 5'h05 && burst_q == BURST_FIXBC4 && $past(cmd) == CMD_NOP
    ##1 cmd == CMD_NOP [*8] |-> ##1 !rd_strobe)
    else $error("chopped burst ran long");
  rl_sum_a: assert property (@(posedge clk) disable iff (!reset_n)
    al_sel_q == AL_CL2 |-> rl == {cl_q, 1'b0} - 5'h02)
    else $error("read latency wrong");
  anpd_a: assert property (@(posedge clk) disable iff (!reset_n)
    odt_anpd == rl - {1'b0, cl_q} + {1'b0, cwl_q} - 5'h01)
    else $error("odt window wrong");
  ref_idle_a: assert property (@(posedge clk) disable iff (!reset_n)
    cmd == CMD_REF && open_q != '0 |=> seq_error)
    else $error("refresh with open bank not flagged");
  rfc_a: assert property (@(posedge clk) disable iff (!reset_n)
    cmd == CMD_REF ##[1:5] cmd == CMD_ACT |=> seq_error)
    else $error("command inside refresh cycle not flagged");
  beat_kept_a: assert property (@(posedge clk) disable iff (!reset_n)
    rd_strobe |-> buf_ready)
    else $error("read beat dropped by full buffer");
endmodule
`default_nettype wire

// ==== ddrc_ctrl_model.sv ====
// Controller-side model: drives command, bank, address, ODT and CKE.
// Assumes one bench process calls its tasks; lax lets a scenario break rules.
`timescale 1ns/1ps
`default_nettype none
module ddrc_ctrl_model
  import ddrc_pkg::*;
(
  input wire logic clk,
  input wire logic lax,
  output logic [2:0] cmd,
  output logic [2:0] bank,
  output logic [15:0] addr,
  output logic odt,
  output logic cke
);
  // ----------------------------------------------------------------
  // Command driver
  // ----------------------------------------------------------------
  logic [7:0] open_q = 8'h00;
  logic odt_q = 1'b0;
  int hold_q = 0;
  initial begin
    cmd = CMD_NOP;
    bank = 3'h0;
    addr = 16'h0000;
    cke = 1'b1;
  end
  // Unless lax, termination stays up four clocks past a write that raised it.
  assign odt = odt_q | (hold_q > 0);
  always @(posedge clk) begin
    if (cmd == CMD_WR && odt_q && !lax) hold_q <= ODTH4_CYC;
    else if (hold_q > 0) hold_q <= hold_q - 1;
  end
  task automatic send(input logic [2:0] c, input logic [2:0] b, input logic [15:0] a,
    input logic o);
    @(posedge clk);
    cmd <= c;
    bank <= b;
    // An idle address bus is not left holding its last value.
    addr <= (c == CMD_NOP) ? ~addr : a;
    odt_q <= o;
    if (c == CMD_ACT) open_q[b] <= 1'b1;
    if (c == CMD_PRE) open_q <= a[10] ? 8'h00 : open_q & ~(8'h01 << b);
  endtask
  task automatic issue(input logic [2:0] c, input logic [2:0] b, input logic [15:0] a,
    input logic o);
    if (c == CMD_REF && open_q != 8'h00 && !lax) begin
      send(CMD_PRE, 3'h0, 16'h0400, 1'b0);
      repeat (4) send(CMD_NOP, 3'h0, 16'h0000, 1'b0);
    end
    send(c, b, a, o);
    send(CMD_NOP, 3'h0, 16'h0000, 1'b0);
    if (c == CMD_REF && !lax) repeat (TRFC_CYC) send(CMD_NOP, 3'h0, 16'h0000, 1'b0);
  endtask
  task automatic set_cke(input logic v);
    @(posedge clk);
    cke <= v;
  endtask
endmodule
`default_nettype wire

// ==== tb_ddrc_cmd_seq.sv ====
// Self-checking bench for the command sequencer with a controller model.
// Assumes the refresh interval parameter is shortened to keep the run brief.
`timescale 1ns/1ps
`default_nettype none
module tb_ddrc_cmd_seq;
  import ddrc_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and checks
  // ----------------------------------------------------------------
  localparam int REFI = 4;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic lax = 1'b0;
  logic rd_ready = 1'b1;
  logic [15:0] wr_dq = 16'h0000;
  logic [15:0] wd_prev = 16'h0000;
  logic [2:0] cmd, bank;
  logic [15:0] addr, rd_dq, wr_data;
  logic odt, cke, rd_valid, rd_strobe, wr_take, odt_async, seq_error;
  logic [4:0] odt_anpd;
  int n_fail = 0, comparisons = 0, cyc = 0, got = 0, seed = 32'h1ca3;
  int stalls = 0, exp_dq = 0;
  always #25 clk = ~clk;
  ddrc_ctrl_model ddrc_ctrl_model_i (.clk(clk), .lax(lax), .cmd(cmd), .bank(bank),
    .addr(addr), .odt(odt), .cke(cke));
  ddrc_cmd_seq #(.REFI_CYC(REFI)) ddrc_cmd_seq_i (.clk(clk), .reset_n(reset_n), .cmd(cmd),
    .bank(bank), .addr(addr), .odt(odt), .cke(cke), .wr_dq(wr_dq), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rd_dq(rd_dq), .rd_strobe(rd_strobe), .wr_take(wr_take),
    .wr_data(wr_data), .odt_async(odt_async), .odt_anpd(odt_anpd), .seq_error(seq_error));
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // The sink stalls at most once per read burst, which the two-entry buffer absorbs.
  always @(posedge clk) begin
    wd_prev = wr_dq;
    wr_dq <= 16'($random(seed));
    stalls = (rd_strobe === 1'b1) ? stalls + int'(rd_ready !== 1'b1) : 0;
    rd_ready <= (rd_ready && stalls == 0) ? 1'($random(seed)) : 1'b1;
    if (reset_n !== 1'b1) exp_dq = 0;
    if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
      got++;
      check("rd_dq", rd_dq, exp_dq[15:0]);
      exp_dq++;
    end
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      print_verdict();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic do_reset();
    @(posedge clk);
    reset_n <= 1'b0;
    lax <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1;
    check("anpd_rst", odt_anpd, 5'h04);
    check("err_rst", seq_error, 1'b0);
  endtask
  task automatic burst(input logic [2:0] c, input logic a12, input int lat, input int len);
    int n, k;
    ddrc_ctrl_model_i.issue(c, 3'h0, {3'h0, a12, 12'h000}, c == CMD_WR);
    got = 0;
    // A level seen just after an edge is the one that the next edge samples.
    n = 1;
    k = 0;
    while (n < 40 && k == 0) begin
      @(posedge clk);
      #1;
      n++;
      if (c == CMD_WR) check("wr_data", wr_data, wd_prev);
      k = (((c == CMD_RD) ? rd_strobe : wr_take) === 1'b1);
    end
    check("latency", n, lat);
    while (n < 60 && k == 1) begin
      @(posedge clk);
      #1;
      n++;
      k = (((c == CMD_RD) ? rd_strobe : wr_take) === 1'b1);
    end
    check("beats", n - lat, len);
    if (c == CMD_RD) begin
      repeat (6) @(posedge clk);
      check("taken", got, len);
    end
  endtask
  initial begin
    logic [1:0] bm, als;
    int al;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      bm = (i == 0) ? BURST_FIX8 : (i == 3) ? BURST_FIXBC4 : BURST_OTF;
      als = 2'(i % 3);
      al = (als == AL_ZERO) ? 0 : 5 - als;
      ddrc_ctrl_model_i.issue(CMD_MRS, 3'h0, {4'h5, 2'h0, als, 4'h5, 2'h0, bm}, 1'b0);
      repeat (4) @(posedge clk);
      #1;
      check("anpd", odt_anpd, 5'(al + 4));
      burst(CMD_RD, i[0], al + 5, (i < 2) ? 8 : 4);
      burst(CMD_WR, i[0], al + 5, (i < 2) ? 8 : 4);
    end
    do_reset();
    ddrc_ctrl_model_i.issue(CMD_ACT, 3'h2, 16'h0000, 1'b0);
    ddrc_ctrl_model_i.set_cke(1'b0);
    repeat (6) @(posedge clk);
    #1;
    check("apd", odt_async, 1'b0);
    ddrc_ctrl_model_i.set_cke(1'b1);
    ddrc_ctrl_model_i.issue(CMD_REF, 3'h0, 16'h0000, 1'b0);
    repeat (REFI * 6) @(posedge clk);
    ddrc_ctrl_model_i.issue(CMD_REF, 3'h0, 16'h0000, 1'b0);
    check("ref_ok", seq_error, 1'b0);
    ddrc_ctrl_model_i.set_cke(1'b0);
    repeat (6) @(posedge clk);
    #1;
    check("ppd", odt_async, 1'b1);
    ddrc_ctrl_model_i.set_cke(1'b1);
    repeat (6) @(posedge clk);
    #1;
    check("ppd_exit", odt_async, 1'b0);
    for (int e = 0; e < 4; e++) begin
      lax <= 1'b1;
      if (e == 0) ddrc_ctrl_model_i.issue(CMD_ACT, 3'h1, 16'h0000, 1'b0);
      if (e != 3) ddrc_ctrl_model_i.issue(CMD_REF, 3'h0, 16'h0000, 1'b0);
      if (e == 1) ddrc_ctrl_model_i.issue(CMD_ACT, 3'h1, 16'h0000, 1'b0);
      if (e == 2) repeat (REFI * 9) @(posedge clk);
      if (e == 2) ddrc_ctrl_model_i.issue(CMD_REF, 3'h0, 16'h0000, 1'b0);
      if (e == 3) begin
        ddrc_ctrl_model_i.issue(CMD_MRS, 3'h0, {4'h5, 2'h0, 2'h0, 4'h5, 2'h0, BURST_FIXBC4},
          1'b0);
        ddrc_ctrl_model_i.issue(CMD_WR, 3'h0, 16'h0000, 1'b1);
      end
      repeat (3) @(posedge clk);
      #1;
      check("seq_error", seq_error, 1'b1);
      do_reset();
    end
    print_verdict();
  end
endmodule
`default_nettype wire
